/* File: ext_irq_sense_break.sv */
// eight-pin interrupt sense logic and prefetch address break compare
// assumes pins and prefetch bus are synchronous to mclk, apb master
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "irq_consts.svh"

module ext_irq_sense_break (
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              rst_n,
    // register bus
    input  wire irq_pkg::apb_req_t apbReq,
    output irq_pkg::apb_rsp_t      apbRsp,
    // pins and cpu side
    input  wire logic [7:0]        extPins,
    input  wire logic [23:0]       prefetchAddr,
    input  wire logic              prefetchValid,
    input  wire logic              normalMode,
    input  wire logic [7:0]        pinExcAck,
    input  wire logic              breakExcAck,
    // requests
    output logic [7:0]             pinRequest,
    output logic                   breakRequest,
    output logic                   irqOut
);

    irq_pkg::state_t st;
    irq_pkg::state_t next_st;
    logic [7:0]      pinHit;
    logic            brkMatch;
    logic            setup;
    logic            wrAcc;
    logic            rdAcc;

    // two-bit sense field of pin n
    function automatic logic [1:0] senseCode(input logic [7:0] up,
                                             input logic [7:0] lo,
                                             input int         n);
        logic [15:0] both;
        both = {up, lo};
        return both[2*n+1 -: 2];
    endfunction

    function automatic logic senseHit(input logic [1:0] code,
                                      input logic       now,
                                      input logic       prev);
        logic hit;
        unique case (code)
            `SENSE_LOW:  hit = !now;
            `SENSE_FALL: hit = prev & !now;
            `SENSE_RISE: hit = !prev & now;
            `SENSE_BOTH: hit = prev ^ now;
        endcase
        return hit;
    endfunction

    function automatic logic mapped(input logic [`ADDR_W-1:0] a);
        unique case (a)
            `OFF_BRK_HIGH, `OFF_BRK_MID, `OFF_BRK_LOW,
            `OFF_SENSE_UP, `OFF_SENSE_LO, `OFF_ENABLE,
            `OFF_FLAGS, `OFF_BRK_CTRL, `OFF_EVT_STAT,
            `OFF_EVT_MASK: return 1'b1;
            default:       return 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] readMux(input irq_pkg::state_t s,
                                            input logic [`ADDR_W-1:0] a);
        logic [31:0] d;
        d = `ZERO32;
        unique case (a)
            `OFF_BRK_HIGH: d[7:0] = s.brkHigh;
            `OFF_BRK_MID:  d[7:0] = s.brkMid;
            `OFF_BRK_LOW:  d[7:0] = {s.brkLow, 1'b0};
            `OFF_SENSE_UP: d[7:0] = s.senseUp;
            `OFF_SENSE_LO: d[7:0] = s.senseLo;
            `OFF_ENABLE:   d[7:0] = s.enable;
            `OFF_FLAGS:    d[7:0] = s.flags;
            `OFF_BRK_CTRL: begin
                d[`CMF_BIT] = s.condition_match_flag;
                d[`BIE_BIT] = s.break_interrupt_enable;
            end
            `OFF_EVT_STAT: d[`EVT_W-1:0] = s.evtStatus;
            `OFF_EVT_MASK: d[`EVT_W-1:0] = s.evtMask;
            default:       d = `ZERO32;
        endcase
        return d;
    endfunction

    always_comb begin
        next_st = st;
        setup = apbReq.psel & !apbReq.penable;
        wrAcc = apbReq.psel & apbReq.penable & st.rsp.pready
              & apbReq.pwrite;
        rdAcc = apbReq.psel & apbReq.penable & st.rsp.pready
              & !apbReq.pwrite;

        // zero wait: data is latched in setup, ready seen at access
        next_st.rsp.pready = setup;
        next_st.rsp.pslverr = setup & !mapped(apbReq.paddr);
        next_st.rsp.prdata = setup ? readMux(st, apbReq.paddr)
                                   : `ZERO32;

        // register writes take effect at the access edge
        if (wrAcc) begin
            unique case (apbReq.paddr)
                `OFF_BRK_HIGH: next_st.brkHigh = apbReq.pwdata[7:0];
                `OFF_BRK_MID:  next_st.brkMid = apbReq.pwdata[7:0];
                `OFF_BRK_LOW:  next_st.brkLow = apbReq.pwdata[7:1];
                `OFF_SENSE_UP: next_st.senseUp = apbReq.pwdata[7:0];
                `OFF_SENSE_LO: next_st.senseLo = apbReq.pwdata[7:0];
                `OFF_ENABLE:   next_st.enable = apbReq.pwdata[7:0];
                `OFF_BRK_CTRL: next_st.break_interrupt_enable = apbReq.pwdata[`BIE_BIT];
                `OFF_EVT_MASK: next_st.evtMask =
                                   apbReq.pwdata[`EVT_W-1:0];
                default: ;
            endcase
        end

        // a read arms the clear only for bits actually returned as one
        if (rdAcc && apbReq.paddr == `OFF_FLAGS) begin
            next_st.readOne = st.readOne | st.rsp.prdata[7:0];
        end
        if (wrAcc && apbReq.paddr == `OFF_FLAGS) begin
            next_st.readOne = `ZERO8;
        end

        // pin sensing; enable plays no part in setting a flag
        for (int n = 0; n < `PINS; n++) begin
            logic [1:0] code;
            logic       swClr;
            logic       excClr;
            code = senseCode(st.senseUp, st.senseLo, n);
            pinHit[n] = senseHit(code, extPins[n], st.prevPin[n]);
            swClr = wrAcc && apbReq.paddr == `OFF_FLAGS
                  && !apbReq.pwdata[n] && st.readOne[n];
            if (code == `SENSE_LOW) begin
                excClr = pinExcAck[n] & extPins[n];
            end else begin
                excClr = pinExcAck[n];
            end
            // set wins over any clear in the same cycle
            next_st.flags[n] = pinHit[n]
                | (st.flags[n] & !swClr & !excClr);
        end
        next_st.prevPin = extPins;

        // break compare, bit 0 never compared
        brkMatch = prefetchValid
            && (normalMode
                || prefetchAddr[23:16] == st.brkHigh)
            && prefetchAddr[15:8] == st.brkMid
            && prefetchAddr[7:1] == st.brkLow;
        next_st.condition_match_flag = (brkMatch & st.break_interrupt_enable)
                    | (st.condition_match_flag & !breakExcAck);

        // sticky event bits, cleared by reading only what was seen
        next_st.evtStatus = {brkMatch & st.break_interrupt_enable, pinHit}
            | (st.evtStatus
               & ~((rdAcc && apbReq.paddr == `OFF_EVT_STAT)
                   ? st.rsp.prdata[`EVT_W-1:0] : {`EVT_W{1'b0}}));

        // outputs registered from the next state
        next_st.pinRequest = next_st.flags & next_st.enable;
        next_st.breakRequest = next_st.condition_match_flag & next_st.break_interrupt_enable;
        next_st.irqOut = |(next_st.evtStatus & next_st.evtMask);
    end

    // reset clears everything; the level sense default keeps the
    // zero prevPin from faking an edge before software picks a mode
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign apbRsp = st.rsp;
    assign pinRequest = st.pinRequest;
    assign breakRequest = st.breakRequest;
    assign irqOut = st.irqOut;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    sequence brkSeen;
        prefetchValid && st.break_interrupt_enable && prefetchAddr[15:8] == st.brkMid
        && prefetchAddr[7:1] == st.brkLow;
    endsequence

    pin_req_and_a: assert property (
        pinRequest == (st.flags & st.enable))
        else $error("pin request not flag and enable");

    brk_req_and_a: assert property (
        breakRequest == (st.condition_match_flag & st.break_interrupt_enable))
        else $error("break request not match and enable");

    brk_full_set_a: assert property (
        brkSeen and prefetchAddr[23:16] == st.brkHigh |=> st.condition_match_flag)
        else $error("full break match did not set flag");

    brk_normal_a: assert property (
        brkSeen and normalMode |=> st.condition_match_flag)
        else $error("normal mode break match missed");

    brk_high_miss_a: assert property (
        !st.condition_match_flag && !normalMode && prefetchAddr[23:16] != st.brkHigh
        |=> !st.condition_match_flag)
        else $error("high byte mismatch set match flag");

    brk_mid_miss_a: assert property (
        !st.condition_match_flag && prefetchAddr[15:8] != st.brkMid |=> !st.condition_match_flag)
        else $error("mid byte mismatch set match flag");

    brk_no_bie_a: assert property (
        !st.condition_match_flag && !st.break_interrupt_enable |=> !st.condition_match_flag)
        else $error("match flag set while disabled");

    low_bit0_a: assert property (
        setup && apbReq.paddr == `OFF_BRK_LOW |=> !apbRsp.prdata[0])
        else $error("low break bit 0 read as one");

    for (genvar p = 0; p < `PINS; p++) begin : g_pin
        logic [1:0] pc;
        assign pc = senseCode(st.senseUp, st.senseLo, p);

        sequence flagWriteZero;
            wrAcc && apbReq.paddr == `OFF_FLAGS && !apbReq.pwdata[p];
        endsequence

        level_set_a: assert property (
            pc == `SENSE_LOW && !extPins[p] |=> st.flags[p])
            else $error("low level did not set flag");

        fall_set_a: assert property (
            pc == `SENSE_FALL && $fell(extPins[p]) |=> st.flags[p])
            else $error("falling edge did not set flag");

        rise_set_a: assert property (
            pc == `SENSE_RISE && $rose(extPins[p]) |=> st.flags[p])
            else $error("rising edge did not set flag");

        both_set_a: assert property (
            pc == `SENSE_BOTH && $changed(extPins[p]) |=> st.flags[p])
            else $error("edge did not set flag in both mode");

        no_read_keep_a: assert property (
            st.flags[p] && !st.readOne[p] && !pinExcAck[p] |=> st.flags[p])
            else $error("flag cleared without prior read");

        read_clear_a: assert property (
            flagWriteZero and st.readOne[p] && !pinHit[p]
            && !pinExcAck[p] |=> !st.flags[p])
            else $error("read then write zero kept flag");

        write_one_a: assert property (
            st.flags[p] && wrAcc && apbReq.paddr == `OFF_FLAGS
            && apbReq.pwdata[p] |=> st.flags[p])
            else $error("write of one cleared flag");

        level_ack_a: assert property (
            pc == `SENSE_LOW && pinExcAck[p] && extPins[p]
            |=> !st.flags[p])
            else $error("level ack with pin high kept flag");

        edge_ack_a: assert property (
            pc != `SENSE_LOW && pinExcAck[p] && !pinHit[p]
            |=> !st.flags[p])
            else $error("edge ack kept flag");
    end

endmodule // ext_irq_sense_break

/* File: irq_consts.svh */
// constants for the pin sense and address break block
// assumes byte-addressed apb with one 32-bit word per register
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

`define ADDR_W        12
`define PINS          8
`define EVT_W         9
`define OFF_BRK_HIGH  12'h000
`define OFF_BRK_MID   12'h004
`define OFF_BRK_LOW   12'h008
`define OFF_SENSE_UP  12'h00c
`define OFF_SENSE_LO  12'h010
`define OFF_ENABLE    12'h014
`define OFF_FLAGS     12'h018
`define OFF_BRK_CTRL  12'h01c
`define OFF_EVT_STAT  12'h020
`define OFF_EVT_MASK  12'h024

`define SENSE_LOW     2'b00
`define SENSE_FALL    2'b01
`define SENSE_RISE    2'b10
`define SENSE_BOTH    2'b11

`define CMF_BIT       7
`define BIE_BIT       0
`define EVT_BRK_BIT   8
`define ZERO32        32'h0000_0000
`define ZERO8         8'h00

`endif

/* File: irq_pkg.sv */
// types shared by the pin sense and address break block
// assumes irq_consts.svh is on the include path
package irq_pkg;
`include "irq_consts.svh"

    typedef struct packed {
        logic                 psel;
        logic                 penable;
        logic                 pwrite;
        logic [`ADDR_W-1:0]   paddr;
        logic [31:0]          pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [7:0]        brkHigh;
        logic [7:0]        brkMid;
        logic [6:0]        brkLow;
        logic [7:0]        senseUp;
        logic [7:0]        senseLo;
        logic [7:0]        enable;
        logic [7:0]        flags;
        logic [7:0]        readOne;
        logic [7:0]        prevPin;
        logic              condition_match_flag;
        logic              break_interrupt_enable;
        logic [`EVT_W-1:0] evtStatus;
        logic [`EVT_W-1:0] evtMask;
        logic [7:0]        pinRequest;
        logic              breakRequest;
        logic              irqOut;
        apb_rsp_t          rsp;
    } state_t;
endpackage

/* File: cpu_exc_model.sv */
// cpu exception side: acknowledges pending requests on command
// assumes requests are registered on the mclk rising edge
`timescale 1ns/100ps
module cpu_exc_model (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // control and requests
    input  wire logic       ackEnable,
    input  wire logic [7:0] pinRequest,
    input  wire logic       breakRequest,
    // acknowledges
    output logic [7:0]      pinExcAck,
    output logic            breakExcAck
);
    // one-cycle pulses with a gap, so a request still seen
    // in the pulse cycle is not taken twice at once
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinExcAck   <= 8'h00;
            breakExcAck <= 1'b0;
        end else if (ackEnable && pinExcAck == 8'h00 && !breakExcAck) begin
            pinExcAck   <= pinRequest;
            breakExcAck <= breakRequest;
        end else begin
            pinExcAck   <= 8'h00;
            breakExcAck <= 1'b0;
        end
    end
endmodule // cpu_exc_model

/* File: ext_irq_sense_break_tb_top.sv */
// bench for pin sense and address break block
// assumes apb master timing and cpu_exc_model beside the design
`timescale 1ns/100ps
`include "irq_consts.svh"
module ext_irq_sense_break_tb_top;
    typedef struct packed {
        logic [11:0] a;
        logic [31:0] w;
        logic [31:0] r;
        logic        e;
    } row_t;
    logic              mclk, rst_n, prefetchValid, normalMode;
    logic              breakRequest, irqOut, ackEnable, breakExcAck;
    logic              errBit;
    logic [7:0]        extPins, pinExcAck, pinRequest;
    logic [23:0]       prefetchAddr;
    logic [31:0]       rdData;
    irq_pkg::apb_req_t apbReq;
    irq_pkg::apb_rsp_t apbRsp;
    int                nErrors, checks;
    row_t rows[10] = '{
        '{`OFF_BRK_HIGH, 32'ha5, 32'ha5, 1'b0},
        '{`OFF_BRK_MID, 32'h5a, 32'h5a, 1'b0},
        '{`OFF_BRK_LOW, 32'hff, 32'hfe, 1'b0},
        '{`OFF_SENSE_UP, 32'he4, 32'he4, 1'b0},
        '{`OFF_SENSE_LO, 32'he4, 32'he4, 1'b0},
        '{`OFF_ENABLE, 32'h00, 32'h00, 1'b0},
        '{`OFF_FLAGS, 32'hff, 32'h00, 1'b0},
        '{`OFF_BRK_CTRL, 32'h81, 32'h01, 1'b0},
        '{`OFF_EVT_MASK, 32'h1ff, 32'h1ff, 1'b0},
        '{12'h028, 32'hffffffff, 32'h0, 1'b1}};
    // {normal mode, expected, address}; break target a55afe
    logic [25:0] pf[6] = '{{2'b01, 24'ha55afe}, {2'b00, 24'h005afe},
        {2'b01, 24'ha55aff}, {2'b00, 24'ha55bfe},
        {2'b11, 24'h005afe}, {2'b10, 24'hff5afc}};

    ext_irq_sense_break ext_irq_sense_break_inst (
        .mclk(mclk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
        .extPins(extPins), .prefetchAddr(prefetchAddr),
        .prefetchValid(prefetchValid), .normalMode(normalMode),
        .pinExcAck(pinExcAck), .breakExcAck(breakExcAck),
        .pinRequest(pinRequest), .breakRequest(breakRequest),
        .irqOut(irqOut));
    cpu_exc_model cpu_exc_model_inst (
        .mclk(mclk), .rst_n(rst_n), .ackEnable(ackEnable),
        .pinRequest(pinRequest), .breakRequest(breakRequest),
        .pinExcAck(pinExcAck), .breakExcAck(breakExcAck));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task checkWord(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task checkBits(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (apbRsp.pready === 1'b1) break;
        end
        rdData = apbRsp.prdata;
        errBit = apbRsp.pslverr;
        apbReq.psel    <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        checkWord(rdData, exp);
    endtask
    task pins(input logic [7:0] p);
        @(posedge mclk);
        extPins <= p;
        repeat (3) @(posedge mclk);
    endtask
    task ack();
        @(posedge mclk);
        ackEnable <= 1'b1;
        repeat (6) @(posedge mclk);
        ackEnable <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask
    task testDone();
        $display("errors %0d checks %0d", nErrors, checks);
        if (nErrors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // bounded run; far above the cycles the sequence needs
    initial begin
        repeat (20000) @(posedge mclk);
        nErrors++;
        testDone();
    end

    initial begin
        rst_n = 1'b0; apbReq = '0; extPins = 8'hff; prefetchAddr = 24'h0;
        prefetchValid = 1'b0; normalMode = 1'b0; ackEnable = 1'b0;
        nErrors = 0; checks = 0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].a, 32'h0);
            checkBits({7'h0, errBit}, {7'h0, rows[i].e});
            xfer(1'b1, rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].r);
        end
        pins(8'h00);
        rd(`OFF_FLAGS, 32'hbb);
        checkBits(pinRequest, 8'h00);
        pins(8'hff);
        rd(`OFF_FLAGS, 32'hff);
        checkBits({7'h0, irqOut}, 8'h01);
        rd(`OFF_EVT_STAT, 32'hff);
        rd(`OFF_EVT_STAT, 32'h0);
        checkBits({7'h0, irqOut}, 8'h00);
        xfer(1'b1, `OFF_EVT_MASK, 32'h0);
        pins(8'hfd);
        pins(8'hff);
        checkBits({7'h0, irqOut}, 8'h00);
        xfer(1'b1, `OFF_EVT_MASK, 32'h2);
        repeat (2) @(posedge mclk);
        checkBits({7'h0, irqOut}, 8'h01);
        rd(`OFF_EVT_STAT, 32'h2);
        repeat (2) @(posedge mclk);
        checkBits({7'h0, irqOut}, 8'h00);
        // clear needs a prior read; a write disarms it again
        xfer(1'b1, `OFF_FLAGS, 32'h0f);
        xfer(1'b1, `OFF_FLAGS, 32'h00);
        rd(`OFF_FLAGS, 32'h0f);
        xfer(1'b1, `OFF_FLAGS, 32'h00);
        rd(`OFF_FLAGS, 32'h00);
        xfer(1'b1, `OFF_ENABLE, 32'h0f);
        pins(8'h00);
        pins(8'hfe);
        checkBits(pinRequest, 8'h0f);
        ack();
        checkBits(pinRequest, 8'h01);
        rd(`OFF_FLAGS, 32'hf1);
        pins(8'hff);
        ack();
        rd(`OFF_FLAGS, 32'hf0);
        foreach (pf[i]) begin
            @(posedge mclk);
            prefetchAddr  <= pf[i][23:0];
            normalMode    <= pf[i][25];
            prefetchValid <= 1'b1;
            @(posedge mclk);
            prefetchValid <= 1'b0;
            repeat (2) @(posedge mclk);
            checkBits({7'h0, breakRequest}, {7'h0, pf[i][24]});
            ack();
        end
        // reset in mid-run with pins low and requests pending
        pins(8'h00);
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        checkBits({pinRequest[6:0], irqOut}, 8'h00);
        rst_n <= 1'b1;
        rd(`OFF_BRK_HIGH, 32'h0);
        rd(`OFF_FLAGS, 32'hff);
        checkBits(pinRequest, 8'h00);
        testDone();
    end
endmodule // ext_irq_sense_break_tb_top
